// ---- rtl/pcsr_ctrl_status.v ----
// Transceiver control/status register pair behind a management frame slave
`default_nettype none
`include "pcsr_regs.vh"
module pcsr_ctrl_status (
  input wire mclk_i,
  input wire rst_i,
  input wire mdc_i,
  input wire mdio_i,
  output reg mdio_o,
  output reg mdio_oe_o,
  input wire [3:0] mii_txd_i,
  input wire mii_tx_en_i,
  output reg [3:0] mii_rxd_o,
  output reg mii_rx_dv_o,
  output reg mii_col_o,
  output reg [3:0] line_txd_o,
  output reg line_tx_en_o,
  input wire [3:0] line_rxd_i,
  input wire line_rx_dv_i,
  input wire line_col_i,
  input wire coding_sublayer_bypass_i,
  input wire an_speed_100_i,
  input wire an_full_duplex_i,
  input wire autoneg_done_i,
  input wire remote_fault_i,
  input wire link_ok_i,
  input wire jabber_i,
  output reg speed_100_o,
  output reg full_duplex_o,
  output reg power_down_o,
  output reg loop_back_enable_o,
  output reg autoneg_start_o,
  output reg core_reset_o
);

  // ----------------------------------------------------------------
  // Frame state codes
  // ----------------------------------------------------------------
  localparam [3:0] S_PRE = 4'b0001;
  localparam [3:0] S_HDR = 4'b0010;
  localparam [3:0] S_RD = 4'b0100;
  localparam [3:0] S_WR = 4'b1000;

  // Reset image of the control word, sliced one bit at a time on soft reset
  localparam [15:0] CTRL_DEF = `PCSR_CTRL_RESET;

  reg mdc_s1_q, mdc_s2_q, mdc_s3_q;
  reg mdio_s1_q, mdio_s2_q;
  reg [3:0] st_q;
  reg [5:0] cnt_q;
  reg [17:0] sh_q;
  reg [4:0] reg_q;
  reg loop_q, speed_q, an_en_q, pd_q, duplex_q, collision_test_q;
  reg pend_q;
  reg remote_fault_latched_q, link_q, jab_q;

  // ----------------------------------------------------------------
  // Pin synchronisers and clock edge detect
  // ----------------------------------------------------------------
  // Data and clock take equal depth so their relative timing survives
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      mdc_s1_q <= 1'b0;
      mdc_s2_q <= 1'b0;
      mdc_s3_q <= 1'b0;
      mdio_s1_q <= 1'b1;
      mdio_s2_q <= 1'b1;
    end else begin
      mdc_s1_q <= mdc_i;
      mdc_s2_q <= mdc_s1_q;
      mdc_s3_q <= mdc_s2_q;
      mdio_s1_q <= mdio_i;
      mdio_s2_q <= mdio_s1_q;
    end
  end

  wire mdc_rise = mdc_s2_q & ~mdc_s3_q;
  wire mdc_fall = ~mdc_s2_q & mdc_s3_q;
  wire mdio_in = mdio_s2_q;

  // ----------------------------------------------------------------
  // Header decode and register read words
  // ----------------------------------------------------------------
  // Header bits: start second bit, opcode, phy address, register
  wire [12:0] hdr = {sh_q[11:0], mdio_in};
  wire hdr_last = (st_q == S_HDR) && (cnt_q == `PCSR_HDR_LAST) && mdc_rise;
  wire hdr_ok = hdr[12] && (hdr[9:5] == `PCSR_PHY_ADDR);
  wire hdr_rd = hdr_ok && (hdr[11:10] == `PCSR_OP_READ);
  wire hdr_wr = hdr_ok && (hdr[11:10] == `PCSR_OP_WRITE);

  // Self-clearing bits always read zero
  wire [15:0] ctrl_word = {1'b0, loop_q, speed_q, an_en_q, pd_q, 2'b00,
                           duplex_q, collision_test_q, 7'h00};

  // Abilities are a constant except the negotiation ability bit, which is taken from an_en_q
  wire [15:0] stat_word = `PCSR_STAT_FIXED
    | ({15'h0000, autoneg_done_i & an_en_q} << `PCSR_S_ANDONE)
    | ({15'h0000, remote_fault_latched_q} << `PCSR_S_REMOTE_FAULT_LATCHED)
    | ({15'h0000, an_en_q} << `PCSR_S_ANABLE)
    | ({15'h0000, link_q} << `PCSR_S_LINK)
    | ({15'h0000, jab_q} << `PCSR_S_JABBER);

  reg [15:0] rd_word;
  // Unknown addresses answer with zeros rather than being ignored
  always @* begin
    rd_word = `PCSR_ZERO_WORD;
    case (hdr[4:0])
      `PCSR_REG_CTRL: rd_word = ctrl_word;
      `PCSR_REG_STAT: rd_word = stat_word;
      default: rd_word = `PCSR_ZERO_WORD;
    endcase
  end

  // Latches release in the cycle the status word is captured
  wire rd_clr = hdr_last && hdr_rd && (hdr[4:0] == `PCSR_REG_STAT);
  wire wr_go = (st_q == S_WR) && (cnt_q == `PCSR_WR_LAST) && mdc_rise &&
               (reg_q == `PCSR_REG_CTRL);
  wire [15:0] wdata = {sh_q[14:0], mdio_in};
  wire soft_rst = wr_go && wdata[`PCSR_C_RESET];

  // ----------------------------------------------------------------
  // Management frame engine
  // ----------------------------------------------------------------
  // Runs regardless of power-down so the station can always wake it
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= S_PRE;
      cnt_q <= `PCSR_CNT_ZERO;
      sh_q <= 18'h0_0000;
      reg_q <= `PCSR_REG_CTRL;
      mdio_o <= 1'b0;
      mdio_oe_o <= 1'b0;
    end else begin
      case (st_q)
        S_PRE: begin
          if (mdc_rise) begin
            if (mdio_in) begin
              if (cnt_q != `PCSR_PRE_LEN)
                cnt_q <= cnt_q + `PCSR_CNT_ONE;
            end else if (cnt_q == `PCSR_PRE_LEN) begin
              st_q <= S_HDR;
              cnt_q <= `PCSR_CNT_ZERO;
              sh_q <= 18'h0_0000;
            end else begin
              cnt_q <= `PCSR_CNT_ZERO;
            end
          end
        end
        S_HDR: begin
          if (hdr_last) begin
            cnt_q <= `PCSR_CNT_ZERO;
            reg_q <= hdr[4:0];
            if (hdr_rd) begin
              st_q <= S_RD;
              sh_q <= {2'b00, rd_word};
            end else if (hdr_wr) begin
              st_q <= S_WR;
            end else begin
              st_q <= S_PRE;
            end
          end else if (mdc_rise) begin
            sh_q <= {sh_q[16:0], mdio_in};
            cnt_q <= cnt_q + `PCSR_CNT_ONE;
          end
        end
        S_RD: begin
          // First turnaround bit stays released, second is driven low
          if (mdc_fall) begin
            if (cnt_q == `PCSR_RD_DONE) begin
              mdio_oe_o <= 1'b0;
              mdio_o <= 1'b0;
              st_q <= S_PRE;
              cnt_q <= `PCSR_CNT_ZERO;
            end else begin
              mdio_o <= sh_q[17];
              mdio_oe_o <= (cnt_q != `PCSR_CNT_ZERO);
              sh_q <= {sh_q[16:0], 1'b0};
              cnt_q <= cnt_q + `PCSR_CNT_ONE;
            end
          end
        end
        S_WR: begin
          if (mdc_rise) begin
            sh_q <= {sh_q[16:0], mdio_in};
            if (cnt_q == `PCSR_WR_LAST) begin
              st_q <= S_PRE;
              cnt_q <= `PCSR_CNT_ZERO;
            end else begin
              cnt_q <= cnt_q + `PCSR_CNT_ONE;
            end
          end
        end
        default: begin
          st_q <= S_PRE;
          cnt_q <= `PCSR_CNT_ZERO;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control register and negotiation start
  // ----------------------------------------------------------------
  // Soft reset is synchronous so the frame engine is not disturbed
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      loop_q <= 1'b0;
      speed_q <= 1'b1;
      an_en_q <= 1'b1;
      pd_q <= 1'b0;
      duplex_q <= 1'b1;
      collision_test_q <= 1'b0;
      pend_q <= 1'b1;
      autoneg_start_o <= 1'b0;
      core_reset_o <= 1'b0;
    end else if (soft_rst) begin
      loop_q <= CTRL_DEF[`PCSR_C_LOOP];
      speed_q <= CTRL_DEF[`PCSR_C_SPEED];
      an_en_q <= CTRL_DEF[`PCSR_C_ANEN];
      pd_q <= CTRL_DEF[`PCSR_C_POWER_DOWN];
      duplex_q <= CTRL_DEF[`PCSR_C_DUPLEX];
      collision_test_q <= CTRL_DEF[`PCSR_C_COLLISION_TEST];
      pend_q <= 1'b1;
      autoneg_start_o <= 1'b0;
      core_reset_o <= 1'b1;
    end else begin
      core_reset_o <= 1'b0;
      pend_q <= 1'b0;
      autoneg_start_o <= pend_q | (wr_go && wdata[`PCSR_C_ANEN] &&
                         (wdata[`PCSR_C_RESTART] | ~an_en_q));
      if (wr_go) begin
        loop_q <= wdata[`PCSR_C_LOOP];
        an_en_q <= wdata[`PCSR_C_ANEN];
        pd_q <= wdata[`PCSR_C_POWER_DOWN];
        collision_test_q <= wdata[`PCSR_C_COLLISION_TEST];
        // Judged on the enable held before this write
        if (!an_en_q) begin
          speed_q <= wdata[`PCSR_C_SPEED];
          duplex_q <= wdata[`PCSR_C_DUPLEX];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Latched status flags
  // ----------------------------------------------------------------
  // An event in the clearing cycle survives the clear
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      remote_fault_latched_q <= 1'b0;
      link_q <= 1'b0;
      jab_q <= 1'b0;
    end else if (soft_rst) begin
      remote_fault_latched_q <= 1'b0;
      link_q <= 1'b0;
      jab_q <= 1'b0;
    end else begin
      remote_fault_latched_q <= remote_fault_i | (remote_fault_latched_q & ~rd_clr);
      link_q <= link_ok_i & (link_q | rd_clr);
      jab_q <= (jabber_i & ~speed_100_o) | (jab_q & ~rd_clr);
    end
  end

  // ----------------------------------------------------------------
  // Operating mode and data path
  // ----------------------------------------------------------------
  // One register stage on every path keeps outputs glitch free
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      speed_100_o <= 1'b1;
      full_duplex_o <= 1'b1;
      power_down_o <= 1'b0;
      loop_back_enable_o <= 1'b0;
      mii_rxd_o <= 4'h0;
      mii_rx_dv_o <= 1'b0;
      mii_col_o <= 1'b0;
      line_txd_o <= 4'h0;
      line_tx_en_o <= 1'b0;
    end else begin
      speed_100_o <= an_en_q ? an_speed_100_i : speed_q;
      full_duplex_o <= an_en_q ? an_full_duplex_i : duplex_q;
      power_down_o <= pd_q;
      loop_back_enable_o <= loop_q;
      mii_rxd_o <= loop_q ? mii_txd_i : line_rxd_i;
      mii_rx_dv_o <= loop_q ? mii_tx_en_i : line_rx_dv_i;
      line_txd_o <= loop_q ? 4'h0 : mii_txd_i;
      line_tx_en_o <= mii_tx_en_i & ~loop_q;
      if (collision_test_q && !coding_sublayer_bypass_i)
        mii_col_o <= mii_tx_en_i;
      else
        mii_col_o <= line_col_i & ~loop_q;
    end
  end

endmodule
`default_nettype wire

// ---- rtl/pcsr_regs.vh ----
// Constants for the transceiver control and status register pair
`ifndef PCSR_REGS_VH
`define PCSR_REGS_VH

// Management frame format
`define PCSR_PRE_LEN 6'h20
`define PCSR_HDR_LAST 6'h0C
`define PCSR_WR_LAST 6'h11
`define PCSR_RD_DONE 6'h12
`define PCSR_CNT_ZERO 6'h00
`define PCSR_CNT_ONE 6'h01
`define PCSR_OP_READ 2'h2
`define PCSR_OP_WRITE 2'h1
`define PCSR_PHY_ADDR 5'h01

// Register addresses on the management bus
`define PCSR_REG_CTRL 5'h00
`define PCSR_REG_STAT 5'h01

// Control register bit positions
`define PCSR_C_RESET 15
`define PCSR_C_LOOP 14
`define PCSR_C_SPEED 13
`define PCSR_C_ANEN 12
`define PCSR_C_POWER_DOWN 11
`define PCSR_C_RESTART 9
`define PCSR_C_DUPLEX 8
`define PCSR_C_COLLISION_TEST 7

// Status register bit positions
`define PCSR_S_ANDONE 5
`define PCSR_S_REMOTE_FAULT_LATCHED 4
`define PCSR_S_ANABLE 3
`define PCSR_S_LINK 2
`define PCSR_S_JABBER 1

// Reset and fixed values
`define PCSR_CTRL_RESET 16'h3100
`define PCSR_STAT_FIXED 16'h7801
`define PCSR_ZERO_WORD 16'h0000

`endif

// ---- tb/pcsr_checker_assertions.sv ----
// Port checker for the control/status register pair
`default_nettype none
module pcsr_checker (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic mdc_i,
  input wire logic mdio_o,
  input wire logic mdio_oe_o,
  input wire logic [3:0] mii_txd_i,
  input wire logic [3:0] mii_rxd_o,
  input wire logic [3:0] line_rxd_i,
  input wire logic line_tx_en_o,
  input wire logic loop_back_enable_o,
  input wire logic autoneg_start_o,
  input wire logic core_reset_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic mdc_q;
  logic [4:0] rise_q;
  // -------------------------------------------
  // Helper: counts management clock rises while the answer is driven
  // -------------------------------------------
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      mdc_q <= 1'b0;
      rise_q <= 5'h00;
    end else begin
      mdc_q <= mdc_i;
      if (!mdio_oe_o)
        rise_q <= 5'h00;
      else if (mdc_i && !mdc_q)
        rise_q <= rise_q + 5'h01;
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // Loopback echoes transmit nibbles one cycle later; the mode output
  // and the data path are launched from the same bit on the same edge
  a_loop_echo: assert property (
    loop_back_enable_o |-> mii_rxd_o == $past(mii_txd_i))
    else $error("loopback echo wrong");
  a_loop_quiet: assert property (
    loop_back_enable_o |-> !line_tx_en_o)
    else $error("cable sends during loopback");
  // Reset release guard: outputs still hold reset values at first edge
  a_rx_normal: assert property (
    !$past(rst_i) && !loop_back_enable_o
    |-> mii_rxd_o == $past(line_rxd_i))
    else $error("cable receive path wrong");
  a_soft_order: assert property (
    core_reset_o |=> autoneg_start_o && !core_reset_o)
    else $error("soft reset pulse order wrong");
  a_start_once: assert property (
    autoneg_start_o |=> !autoneg_start_o)
    else $error("start pulse longer than one cycle");
  a_start_boot: assert property (
    $fell(rst_i) |-> ##[0:1] autoneg_start_o)
    else $error("no negotiation start after reset");
  a_turn_zero: assert property (
    $rose(mdio_oe_o) |-> !mdio_o)
    else $error("turnaround bit not zero");
  a_answer_len: assert property (
    $fell(mdio_oe_o) |-> rise_q == 5'h11)
    else $error("answer length wrong");
endmodule
bind pcsr_ctrl_status pcsr_checker pcsr_checker_inst (.mclk_i, .rst_i,
  .mdc_i, .mdio_o, .mdio_oe_o, .mii_txd_i, .mii_rxd_o, .line_rxd_i,
  .line_tx_en_o, .loop_back_enable_o, .autoneg_start_o, .core_reset_o);
`default_nettype wire

// ---- tb/pcsr_mac_model.sv ----
// Station management model issuing management frames
`default_nettype none
module pcsr_mac_model (
  input wire logic mclk_i,
  input wire logic mdio_i,
  output logic mdc_o = 1'b0,
  output logic mdio_o = 1'b0,
  output logic mdio_en_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic got;
  // One slow period: low half, rise and sample, high half, fall
  task automatic period(input logic b);
    mdio_o = b;
    repeat (10) @(posedge mclk_i);
    #1 mdc_o = 1'b1;
    got = mdio_i;
    repeat (10) @(posedge mclk_i);
    #1 mdc_o = 1'b0;
  endtask
  // Whole frame; clock stands low between frames
  task automatic frame(input logic [1:0] op, input logic [4:0] pa,
    input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] w;
    w = {32'hFFFF_FFFF, 2'b01, op, pa, ra, 2'b10, wd};
    rd = 16'h0000;
    mdio_en_o = 1'b1;
    for (int i = 63; i >= 18; i--)
      period(w[i]);
    mdio_en_o = (op == 2'h1);
    for (int i = 17; i >= 0; i--) begin
      period(w[i]);
      if (i < 16)
        rd[i] = got;
    end
    mdio_en_o = 1'b0;
    // Let the answer release the line before the next preamble
    repeat (8) @(posedge mclk_i);
    #1;
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the control/status register pair
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, rst = 1, mdc, mdo, moe, mac_d, mac_en;
  logic [3:0] txd = 4'h0, lrxd = 4'h3, rxd, ltxd;
  logic tx_en = 0, lrx_dv = 0, lcol = 0, byp = 0, an_spd = 0, an_fd = 1;
  logic an_done = 0, rflt = 0, lnk = 1, jabber_latched = 0;
  logic spd, fd, pd, loop, rxdv, lcol_o;
  logic [15:0] r;
  int fails = 0, n_compared = 0;
  wire mdio_w;
  // Pull-up holds the line high when nobody drives it
  assign mdio_w = moe ? mdo : (mac_en ? mac_d : 1'b1);
  pcsr_ctrl_status pcsr_ctrl_status_inst (.mclk_i(mclk), .rst_i(rst),
    .mdc_i(mdc), .mdio_i(mdio_w), .mdio_o(mdo), .mdio_oe_o(moe),
    .mii_txd_i(txd), .mii_tx_en_i(tx_en), .mii_rxd_o(rxd),
    .mii_rx_dv_o(rxdv), .mii_col_o(lcol_o), .line_txd_o(ltxd),
    .line_tx_en_o(), .line_rxd_i(lrxd), .line_rx_dv_i(lrx_dv),
    .line_col_i(lcol), .coding_sublayer_bypass_i(byp),
    .an_speed_100_i(an_spd), .an_full_duplex_i(an_fd),
    .autoneg_done_i(an_done), .remote_fault_i(rflt), .link_ok_i(lnk),
    .jabber_i(jabber_latched), .speed_100_o(spd), .full_duplex_o(fd),
    .power_down_o(pd), .loop_back_enable_o(loop),
    .autoneg_start_o(), .core_reset_o());
  pcsr_mac_model pcsr_mac_model_inst (.mclk_i(mclk), .mdio_i(mdio_w),
    .mdc_o(mdc), .mdio_o(mac_d), .mdio_en_o(mac_en));
  initial begin
    forever #5 mclk = ~mclk;
  end
  // -------------------------------------------
  // Compare and bus tasks
  // -------------------------------------------
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk16({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic wr(input logic [15:0] d);
    pcsr_mac_model_inst.frame(2'h1, 5'h01, 5'h00, d, r);
  endtask
  task automatic rchk(input logic [4:0] pa, input logic [4:0] ra,
    input logic [15:0] e);
    pcsr_mac_model_inst.frame(2'h2, pa, ra, 16'h0000, r);
    chk16(r, e);
  endtask
  // -------------------------------------------
  // Scenarios
  // -------------------------------------------
  task automatic t_defaults;
    rchk(5'h01, 5'h00, 16'h3100);
    rchk(5'h01, 5'h01, 16'h7809);
    rchk(5'h01, 5'h01, 16'h780D);
    chk1(spd, 1'b0);
    $display("defaults done");
  endtask
  // Old enable still on, so the first clear keeps speed and duplex
  task automatic t_forced;
    wr(16'h1000);
    rchk(5'h01, 5'h00, 16'h3100);
    wr(16'h0000);
    rchk(5'h01, 5'h00, 16'h2100);
    wr(16'h247F);
    rchk(5'h01, 5'h00, 16'h2000);
    chk1(spd, 1'b1);
    chk1(fd, 1'b0);
    wr(16'h0100);
    chk1(spd, 1'b0);
    rchk(5'h01, 5'h01, 16'h7805);
    $display("forced done");
  endtask
  task automatic t_latch;
    @(posedge mclk);
    #1 rflt = 1;
    jabber_latched = 1;
    lnk = 0;
    @(posedge mclk);
    #1 rflt = 0;
    jabber_latched = 0;
    lnk = 1;
    rchk(5'h01, 5'h01, 16'h7813);
    rchk(5'h01, 5'h01, 16'h7805);
    $display("latch done");
  endtask
  task automatic t_loop;
    wr(16'h4080);
    txd = 4'hA;
    tx_en = 1;
    repeat (2) @(posedge mclk);
    #1 chk16({12'h000, rxd}, 16'h000A);
    chk1(rxdv, 1'b1);
    chk16({12'h000, ltxd}, 16'h0000);
    chk1(loop, 1'b1);
    chk1(lcol_o, 1'b1);
    byp = 1;
    repeat (2) @(posedge mclk);
    #1 chk1(lcol_o, 1'b0);
    byp = 0;
    tx_en = 0;
    $display("loop done");
  endtask
  // Loopback off again: cable paths carry data once more
  task automatic t_power;
    wr(16'h0800);
    chk1(pd, 1'b1);
    chk1(loop, 1'b0);
    chk16({12'h000, ltxd}, 16'h000A);
    chk16({12'h000, rxd}, 16'h0003);
    rchk(5'h01, 5'h00, 16'h0800);
    rchk(5'h02, 5'h00, 16'hFFFF);
    rchk(5'h01, 5'h05, 16'h0000);
    $display("power done");
  endtask
  task automatic t_soft;
    an_done = 1;
    wr(16'h1200);
    rchk(5'h01, 5'h00, 16'h1000);
    wr(16'h8000);
    rchk(5'h01, 5'h00, 16'h3100);
    rchk(5'h01, 5'h01, 16'h7829);
    rchk(5'h01, 5'h01, 16'h782D);
    $display("soft reset done");
  endtask
  task automatic close_out;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    #1 rst = 0;
    t_defaults;
    t_forced;
    t_latch;
    t_loop;
    t_power;
    t_soft;
    close_out;
  end
  // Watchdog well past the roughly 31k cycles the frames need
  initial begin
    repeat (90000) @(posedge mclk);
    fails++;
    close_out;
  end
endmodule
`default_nettype wire
